// ### hdl/isio_pkg.sv
// Shared constants for the ISA slave I/O window and its host-side master.
// Assumes a single 50 MHz clock and synchronous, active-low reset.
package isio_pkg;

	////////////////////////////////////////////////////////////////////
	// ISA address and I/O window layout
	localparam int        SA_W       = 10;     // I/O address lines
	localparam int        BASE_W     = 5;      // Base compare bits
	localparam logic [4:0] OFF_DATA  = 5'h10;  // Controller data port
	localparam logic [4:0] OFF_INDEX = 5'h12;  // Shared index pointer
	localparam logic [4:0] OFF_RESET = 5'h14;  // Read-triggered reset
	localparam logic [4:0] OFF_CFG   = 5'h16;  // Configuration data port
	localparam logic [4:0] OFF_LIMIT = 5'h18;  // First offset not claimed
	localparam logic [15:0] INDEX_RST = 16'h0000;

	////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_NS         = 20;
	localparam int STROBE_MIN_NS  = 100;
	localparam int STROBE_MIN_CYC = (STROBE_MIN_NS + CLK_NS - 1) / CLK_NS;

	////////////////////////////////////////////////////////////////////
	// Host command registers on APB
	localparam logic [7:0] HREG_CTRL   = 8'h00;
	localparam logic [7:0] HREG_WDATA  = 8'h04;
	localparam logic [7:0] HREG_RDATA  = 8'h08;
	localparam logic [7:0] HREG_STATUS = 8'h0c;
	localparam logic [7:0] HREG_BASE   = 8'h10;
	localparam int CTRL_OFF_LSB  = 0;
	localparam int CTRL_WR_BIT   = 8;
	localparam int CTRL_WORD_BIT = 9;
	localparam int CTRL_GO_BIT   = 31;
	localparam int STAT_BUSY     = 0;
	localparam int STAT_DONE     = 1;
	localparam int STAT_CS16     = 2;
	localparam int STAT_SPLIT    = 3;
	localparam logic [4:0] BASE_RST = 5'h00;

endpackage

// ### hdl/isio_isa_if.sv
// ISA I/O slave bus between the host master and the network device.
// Resolves the shared data lanes and the open-drain lines with pull-ups.
interface isio_isa_if;
	logic [9:0]  sa;
	logic        aen;
	logic        ior_n;
	logic        iow_n;
	logic        sbhe_n;
	logic [15:0] host_sd_o;
	logic [1:0]  host_sd_oe;
	logic [15:0] dev_sd_o;
	logic [1:0]  dev_sd_oe;
	logic        dev_rdy_oe;
	logic        dev_cs16_oe;
	logic [15:0] sd;
	logic        iochrdy;
	logic        iocs16_n;

	// Lane resolution; an undriven lane floats high
	assign sd[7:0]  = dev_sd_oe[0] ? dev_sd_o[7:0] :
		(host_sd_oe[0] ? host_sd_o[7:0] : 8'hff);
	assign sd[15:8] = dev_sd_oe[1] ? dev_sd_o[15:8] :
		(host_sd_oe[1] ? host_sd_o[15:8] : 8'hff);
	assign iochrdy  = ~dev_rdy_oe;
	assign iocs16_n = ~dev_cs16_oe;

	modport dev (input sa, aen, ior_n, iow_n, sbhe_n, sd,
		output dev_sd_o, dev_sd_oe, dev_rdy_oe, dev_cs16_oe);
	modport host (output sa, aen, ior_n, iow_n, sbhe_n, host_sd_o,
		host_sd_oe, input sd, iochrdy, iocs16_n);
endinterface

// ### hdl/isio_device.sv
// ISA slave I/O access logic of the network device.
// Assumes ISA pins synchronous to I_CLOCK and registers behind a req/ack port.
module isio_device (
	// Clock and reset
	input  wire logic         I_CLOCK,
	input  wire logic         I_RST_N,
	// ISA pins
	isio_isa_if.dev           ISA,
	// Static configuration and straps
	input  wire logic [4:0]   I_BASE,
	input  wire logic         I_IO16,
	input  wire logic         I_SYS8BIT,
	input  wire logic         I_SLAVE_MODE,
	input  wire logic         I_PIO_MODE,
	input  wire logic         I_MASTER_REQ,
	input  wire logic [7:0]   I_BOOT_BASE_CFG,
	input  wire logic [7:0]   I_BOOT_MEM_BASE_STRAP,
	input  wire logic [127:0] I_STATION,
	// Internal register port
	output logic              O_REG_REQ,
	output logic              O_REG_WR,
	output logic              O_REG_CFG,
	output logic [15:0]       O_REG_INDEX,
	output logic [15:0]       O_REG_WDATA,
	input  wire logic [15:0]  I_REG_RDATA,
	input  wire logic         I_REG_ACK,
	// Mode outputs
	output logic              O_SOFT_RESET,
	output logic [7:0]        O_BOOT_BASE,
	output logic              O_SRAM_SHARED_EN,
	output logic              O_SRAM_PIO_EN,
	output logic              O_MASTER_EN
);

	typedef enum logic [1:0] {S_IDLE, S_ACC, S_HOLD} isio_dst_t;

	typedef struct packed {
		isio_dst_t   state;
		logic [15:0] index;
		logic [7:0]  wr_hold;
		logic [7:0]  rd_hold;
		logic [15:0] sd_out;
		logic [1:0]  sd_oe;
		logic        rdy_oe;
		logic        req;
		logic        wr;
		logic        cfg;
		logic [15:0] wdata;
		logic [15:0] bus_wd;
		logic [4:0]  off;
		logic        odd;
		logic        wide;
		logic        is_wr;
		logic        soft_rst;
		logic [7:0]  boot_base;
		logic        sram_shared;
		logic        sram_pio;
		logic        master_en;
	} isio_dev_st_t;

	isio_dev_st_t st;
	isio_dev_st_t next_st;

	logic       hit;
	logic       strobe;
	logic       io16;
	logic       wide16;
	logic [7:0] wbyte;

	////////////////////////////////////////////////////////////////////
	// Word of the station area at a byte offset
	function automatic logic [15:0] station_word(input logic [4:0] off,
		input logic [127:0] sta);
		station_word = sta[{off[3:1], 4'h0} +: 16];
	endfunction

	// Place a word on the lanes for the access type
	function automatic logic [17:0] place(input logic [15:0] w,
		input logic odd, input logic wide, input logic io16);
		if (io16 && wide) begin
			place = {2'b11, w};
		end else if (io16 && odd) begin
			place = {2'b10, w[15:8], 8'h00};
		end else if (odd) begin
			place = {2'b01, 8'h00, w[15:8]};
		end else begin
			place = {2'b01, 8'h00, w[7:0]};
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// Address decode; AEN low and base match gate every claim
	assign hit    = !ISA.aen && ISA.sa[9:5] == I_BASE
		&& ISA.sa[4:0] < isio_pkg::OFF_LIMIT;
	assign strobe = !ISA.ior_n || !ISA.iow_n;
	// Word cycles need 16-bit ports; SBHE floats in an 8-bit system
	assign io16   = I_IO16 && !I_SYS8BIT;
	assign wide16 = io16 && !ISA.sbhe_n && !ISA.sa[0];
	// In 8-bit mode the master has already swapped the odd byte down
	assign wbyte  = (io16 && ISA.sa[0]) ? ISA.sd[15:8] : ISA.sd[7:0];

	////////////////////////////////////////////////////////////////////
	// IOCS16 only in 16-bit systems; gated off for reset port offset 14h but not 15h
	assign ISA.dev_cs16_oe = hit && I_IO16 && !I_SYS8BIT
		&& ISA.sa[4:0] != isio_pkg::OFF_RESET;

	assign ISA.dev_sd_o    = st.sd_out;
	assign ISA.dev_sd_oe   = st.sd_oe;
	assign ISA.dev_rdy_oe  = st.rdy_oe;
	assign O_REG_REQ       = st.req;
	assign O_REG_WR        = st.wr;
	assign O_REG_CFG       = st.cfg;
	assign O_REG_INDEX     = st.index;
	assign O_REG_WDATA     = st.wdata;
	assign O_SOFT_RESET    = st.soft_rst;
	assign O_BOOT_BASE     = st.boot_base;
	assign O_SRAM_SHARED_EN = st.sram_shared;
	assign O_SRAM_PIO_EN   = st.sram_pio;
	assign O_MASTER_EN     = st.master_en;

	////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic [17:0] lanes;
		logic [15:0] bw;
		lanes = '0;
		bw = '0;
		next_st = st;
		next_st.soft_rst = 1'b0;

		// Straps: boot base from strap only in slave mode
		next_st.boot_base = I_SLAVE_MODE ? I_BOOT_MEM_BASE_STRAP
			: I_BOOT_BASE_CFG;
		next_st.sram_shared = I_SLAVE_MODE && !I_PIO_MODE;
		next_st.sram_pio    = I_SLAVE_MODE && I_PIO_MODE;
		// Mastering only outside 8-bit systems and never in slave mode
		next_st.master_en = I_MASTER_REQ && !I_SLAVE_MODE
			&& !I_SYS8BIT;

		case (st.state)
			S_IDLE: begin
				if (hit && strobe) begin
					next_st.state  = S_ACC;
					next_st.rdy_oe = 1'b1;
					next_st.off    = ISA.sa[4:0];
					next_st.odd    = ISA.sa[0];
					next_st.wide   = wide16;
					next_st.is_wr  = !ISA.iow_n;
					next_st.bus_wd = {ISA.sd[15:8], wbyte};
				end
			end
			S_ACC: begin
				bw = st.bus_wd;
				if (st.req) begin
					// Waiting on the register behind the data port
					if (I_REG_ACK) begin
						next_st.req = 1'b0;
						if (!st.wr) begin
							next_st.rd_hold = I_REG_RDATA[15:8];
							lanes = place(I_REG_RDATA, st.odd, st.wide,
								io16);
							next_st.sd_out = lanes[15:0];
							next_st.sd_oe  = lanes[17:16];
						end
						next_st.state  = S_HOLD;
						next_st.rdy_oe = 1'b0;
					end
				end else begin
					next_st.state  = S_HOLD;
					next_st.rdy_oe = 1'b0;
					if (st.off < isio_pkg::OFF_DATA) begin
						// Station area is read-only
						if (!st.is_wr) begin
							lanes = place(station_word(st.off, I_STATION),
								st.odd, st.wide, io16);
						end
					end else if (st.off[4:1] == isio_pkg::OFF_RESET[4:1]) begin
						if (!st.is_wr) begin
							next_st.soft_rst = 1'b1;
							next_st.index    = isio_pkg::INDEX_RST;
							next_st.wr_hold  = 8'h00;
							lanes = {2'b01, 16'h0000};
						end
					end else if (st.off[4:1] == isio_pkg::OFF_INDEX[4:1]) begin
						if (st.is_wr) begin
							if (st.wide) begin
								next_st.index = bw;
							end else if (!st.odd) begin
								next_st.wr_hold = bw[7:0];
							end else begin
								next_st.index = {bw[7:0], st.wr_hold};
							end
						end else begin
							lanes = place(st.index, st.odd, st.wide, io16);
						end
					end else begin
						// Controller or configuration data port
						next_st.cfg = st.off[4:1] == isio_pkg::OFF_CFG[4:1];
						if (st.is_wr && st.wide) begin
							next_st.req   = 1'b1;
							next_st.wr    = 1'b1;
							next_st.wdata = bw;
						end else if (st.is_wr && !st.odd) begin
							next_st.wr_hold = bw[7:0];
						end else if (st.is_wr) begin
							next_st.req   = 1'b1;
							next_st.wr    = 1'b1;
							next_st.wdata = {bw[7:0], st.wr_hold};
						end else if (st.odd && !io16) begin
							// Second half of a split read: no new access
							lanes = place({st.rd_hold, 8'h00}, 1'b1, 1'b0,
								1'b0);
						end else begin
							next_st.req = 1'b1;
							next_st.wr  = 1'b0;
						end
						if (next_st.req) begin
							next_st.state  = S_ACC;
							next_st.rdy_oe = 1'b1;
						end
					end
					if (!st.is_wr && !next_st.req) begin
						next_st.sd_out = lanes[15:0];
						next_st.sd_oe  = lanes[17:16];
					end
				end
			end
			S_HOLD: begin
				// Data stays on the bus until the command strobe ends
				if (!strobe) begin
					next_st.state = S_IDLE;
					next_st.sd_oe = 2'b00;
				end
			end
			default: begin
				next_st.state = S_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule

// ### hdl/isio_host.sv
// ISA host master that runs I/O cycles on orders taken over APB.
// Assumes the device end on the same interface and clock.
module isio_host (
	// Clock and reset
	input  wire logic        I_CLOCK,
	input  wire logic        I_RST_N,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// ISA pins
	isio_isa_if.host         ISA
);

	typedef enum logic [1:0] {H_IDLE, H_ADDR, H_STRB, H_END} isio_hst_t;

	typedef struct packed {
		isio_hst_t   state;
		logic [4:0]  base;
		logic [4:0]  off;
		logic        wr;
		logic        word;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic        busy;
		logic        done;
		logic        cs16;
		logic        split;
		logic        second;
		logic [2:0]  cnt;
		logic [9:0]  sa;
		logic        aen;
		logic        ior_n;
		logic        iow_n;
		logic        sbhe_n;
		logic [15:0] sd_o;
		logic [1:0]  sd_oe;
		logic [31:0] prdata;
		logic        pslverr;
	} isio_host_st_t;

	isio_host_st_t st;
	isio_host_st_t next_st;
	logic          apb_wr;

	assign apb_wr     = PSEL && PENABLE && PWRITE;
	assign PREADY     = 1'b1;
	assign PRDATA     = st.prdata;
	assign PSLVERR    = st.pslverr;
	assign ISA.sa     = st.sa;
	assign ISA.aen    = st.aen;
	assign ISA.ior_n  = st.ior_n;
	assign ISA.iow_n  = st.iow_n;
	assign ISA.sbhe_n = st.sbhe_n;
	assign ISA.host_sd_o  = st.sd_o;
	assign ISA.host_sd_oe = st.sd_oe;

	////////////////////////////////////////////////////////////////////
	// Next-state logic: APB registers and the ISA cycle sequencer
	always_comb begin
		next_st = st;
		// Read data is prepared in the setup cycle, ready at access
		if (PSEL && !PENABLE) begin
			next_st.pslverr = 1'b0;
			next_st.prdata  = '0;
			case (PADDR)
				isio_pkg::HREG_CTRL: next_st.prdata = {22'h0, st.word,
					st.wr, 3'h0, st.off};
				isio_pkg::HREG_WDATA:  next_st.prdata = {16'h0, st.wdata};
				isio_pkg::HREG_RDATA:  next_st.prdata = {16'h0, st.rdata};
				isio_pkg::HREG_STATUS: next_st.prdata = {28'h0, st.split,
					st.cs16, st.done, st.busy};
				isio_pkg::HREG_BASE:   next_st.prdata = {27'h0, st.base};
				default: next_st.pslverr = 1'b1;
			endcase
		end
		if (apb_wr && PADDR == isio_pkg::HREG_WDATA) begin
			next_st.wdata = PWDATA[15:0];
		end
		if (apb_wr && PADDR == isio_pkg::HREG_BASE) begin
			next_st.base = PWDATA[4:0];
		end

		case (st.state)
			H_IDLE: begin
				// Orders while busy never reach here, so they are dropped
				if (apb_wr && PADDR == isio_pkg::HREG_CTRL
					&& PWDATA[isio_pkg::CTRL_GO_BIT]) begin
					next_st.off    = PWDATA[isio_pkg::CTRL_OFF_LSB +: 5];
					next_st.wr     = PWDATA[isio_pkg::CTRL_WR_BIT];
					// A word must start on an even offset
					next_st.word   = PWDATA[isio_pkg::CTRL_WORD_BIT]
						&& !PWDATA[isio_pkg::CTRL_OFF_LSB];
					next_st.busy   = 1'b1;
					next_st.done   = 1'b0;
					next_st.split  = 1'b0;
					next_st.second = 1'b0;
					next_st.state  = H_ADDR;
					next_st.aen    = 1'b0;
					next_st.sa     = {st.base, next_st.off};
					// Odd byte always pairs A0 high with SBHE low
					next_st.sbhe_n = !(next_st.word || next_st.off[0]);
				end
			end
			H_ADDR: begin
				next_st.cs16  = !ISA.iocs16_n;
				next_st.cnt   = '0;
				next_st.state = H_STRB;
				next_st.ior_n = st.wr;
				next_st.iow_n = !st.wr;
				if (st.wr) begin
					// Odd bytes are copied to both lanes for 8-bit slaves
					next_st.sd_oe = 2'b11;
					next_st.sd_o  = (st.second || st.off[0])
						? {st.wdata[15:8], st.wdata[15:8]} : st.wdata;
				end
			end
			H_STRB: begin
				if (st.cnt != 3'(isio_pkg::STROBE_MIN_CYC - 1)) begin
					next_st.cnt = st.cnt + 3'd1;
				end else if (ISA.iochrdy) begin
					if (!st.wr) begin
						if (st.second) begin
							next_st.rdata[15:8] = ISA.sd[7:0];
						end else if (st.word && st.cs16) begin
							next_st.rdata = ISA.sd;
						end else if (st.off[0]) begin
							next_st.rdata[15:8] = st.cs16 ? ISA.sd[15:8]
								: ISA.sd[7:0];
						end else begin
							next_st.rdata[7:0] = ISA.sd[7:0];
						end
					end
					next_st.ior_n = 1'b1;
					next_st.iow_n = 1'b1;
					next_st.sd_oe = 2'b00;
					next_st.state = H_END;
				end
			end
			H_END: begin
				if (st.word && !st.cs16 && !st.second) begin
					// Low byte done, now the high byte
					next_st.second = 1'b1;
					next_st.split  = 1'b1;
					next_st.sa[0]  = 1'b1;
					next_st.sbhe_n = 1'b0;
					next_st.state  = H_ADDR;
				end else begin
					next_st.aen   = 1'b1;
					next_st.busy  = 1'b0;
					next_st.done  = 1'b1;
					next_st.state = H_IDLE;
				end
			end
			default: begin
				next_st.state = H_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// State register; AEN, the strobes and SBHE idle high after reset
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			st        <= '0;
			st.base   <= isio_pkg::BASE_RST;
			st.aen    <= 1'b1;
			st.ior_n  <= 1'b1;
			st.iow_n  <= 1'b1;
			st.sbhe_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

endmodule

// ### bench/isio_chk.sv
// Checker for the ISA slave window, watching the shared bus lines.
// Assumes one clock domain and the device straps passed alongside.
module isio_chk (
	// Clock, reset and straps
	input  wire logic       I_CLOCK,
	input  wire logic       I_RST_N,
	input  wire logic [4:0] I_BASE,
	input  wire logic       I_IO16,
	input  wire logic       I_SYS8BIT,
	// Bus lines
	input  wire logic [9:0] sa,
	input  wire logic       aen,
	input  wire logic       ior_n,
	input  wire logic       iow_n,
	input  wire logic [1:0] dev_sd_oe,
	input  wire logic       dev_rdy_oe,
	input  wire logic       dev_cs16_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	logic hit;
	logic strb;
	logic wide;
	logic rst_port;
	logic data_port;

	////////////////////////////////////////////////////////////////////
	// Claim decode, kept apart so each property reads plainly
	assign hit       = !aen && sa[9:5] == I_BASE && sa[4:0] < 5'h18;
	assign strb      = !ior_n || !iow_n;
	assign wide      = I_IO16 && !I_SYS8BIT;
	assign rst_port  = sa[4:1] == 4'ha;
	assign data_port = sa[4:1] == 4'h8 || sa[4:1] == 4'hb;

	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (!I_RST_N);

	////////////////////////////////////////////////////////////////////
	// Steps of a claimed cycle
	sequence s_start;
		hit && strb && !$past(strb);
	endsequence
	sequence s_quick;
		$rose(dev_rdy_oe) && !data_port;
	endsequence

	////////////////////////////////////////////////////////////////////
	// Properties
	chk_claim_pull:
		assert property (s_start |-> ##[1:2] dev_rdy_oe)
		else $error("ready not pulled low on claim");
	chk_quick_release:
		assert property (s_quick |-> ##[1:2] !dev_rdy_oe)
		else $error("ready held too long");
	chk_ignore_out:
		assert property (!hit && !$past(hit) && !$past(hit, 2)
			|-> !dev_rdy_oe && dev_sd_oe == 2'b00)
		else $error("device answered an unclaimed cycle");
	chk_cs16_reset:
		assert property (hit && rst_port |-> !dev_cs16_oe)
		else $error("cs16 asserted on reset port");
	chk_cs16_narrow:
		assert property (hit && !wide |-> !dev_cs16_oe)
		else $error("cs16 asserted in 8-bit mode");
	chk_cs16_wide:
		assert property (hit && wide && !rst_port |-> dev_cs16_oe)
		else $error("cs16 missing in 16-bit mode");
	chk_lanes_end:
		assert property (!strb && !$past(strb) |-> dev_sd_oe == 2'b00)
		else $error("lanes driven after strobe end");
	chk_write_quiet:
		assert property (!iow_n && !$past(iow_n) |-> dev_sd_oe == 2'b00)
		else $error("device drove lanes in a write");
	chk_narrow_lane:
		assert property (hit && !ior_n && !wide |-> !dev_sd_oe[1])
		else $error("high lane driven in 8-bit mode");
	chk_odd_lane:
		assert property (hit && !ior_n && wide && !rst_port && sa[0]
			|-> !dev_sd_oe[0])
		else $error("low lane driven on odd byte");
endmodule

// ### bench/isa_slave_io_access_tb_top.sv
// Bench: host master and device joined on one ISA bus, host run over APB.
// Assumes the package, bus interface and both design ends compiled first.
module isa_slave_io_access_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [127:0] STATION = 128'hafaeadacabaaa9a8a7a6a5a4a3a2a1a0;
	localparam logic [4:0]   BASE    = 5'h0a;

	logic        clock, rst_n, io16, sys8, slave, pio, mreq;
	logic [7:0]  boot_cfg, boot_strap, boot_base, paddr;
	logic        psel, penable, pwrite, pready, pslverr, perr;
	logic [31:0] pwdata, prdata, q;
	logic        reg_req, reg_wr, reg_cfg, soft_rst;
	logic        reg_ack = 1'b0;
	logic [15:0] reg_idx, reg_wd, reg_rd, rd;
	logic        sram_sh, sram_pio, master_en;
	logic [33:0] last;
	logic [3:0]  st;
	int          reg_lat, n0, s0;
	int          wait_cnt = 0, n_req = 0, n_soft = 0;
	int          err_total, n_checks;

	////////////////////////////////////////////////////////////////////
	// Both ends and the checker on one bus
	isio_isa_if isa_bus ();
	isio_device isio_device_i (.I_CLOCK(clock), .I_RST_N(rst_n),
		.ISA(isa_bus), .I_BASE(BASE), .I_IO16(io16), .I_SYS8BIT(sys8),
		.I_SLAVE_MODE(slave), .I_PIO_MODE(pio), .I_MASTER_REQ(mreq),
		.I_BOOT_BASE_CFG(boot_cfg), .I_BOOT_MEM_BASE_STRAP(boot_strap),
		.I_STATION(STATION), .O_REG_REQ(reg_req), .O_REG_WR(reg_wr),
		.O_REG_CFG(reg_cfg), .O_REG_INDEX(reg_idx), .O_REG_WDATA(reg_wd),
		.I_REG_RDATA(reg_rd), .I_REG_ACK(reg_ack), .O_SOFT_RESET(soft_rst),
		.O_BOOT_BASE(boot_base), .O_SRAM_SHARED_EN(sram_sh),
		.O_SRAM_PIO_EN(sram_pio), .O_MASTER_EN(master_en));
	isio_host isio_host_i (.I_CLOCK(clock), .I_RST_N(rst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ISA(isa_bus));
	isio_chk isio_chk_i (.I_CLOCK(clock), .I_RST_N(rst_n), .I_BASE(BASE),
		.I_IO16(io16), .I_SYS8BIT(sys8), .sa(isa_bus.sa), .aen(isa_bus.aen),
		.ior_n(isa_bus.ior_n), .iow_n(isa_bus.iow_n),
		.dev_sd_oe(isa_bus.dev_sd_oe), .dev_rdy_oe(isa_bus.dev_rdy_oe),
		.dev_cs16_oe(isa_bus.dev_cs16_oe));

	// 50 MHz clock
	always #10 clock = ~clock;

	// Register responder; a latency above zero stalls the device
	always @(posedge clock) begin
		reg_ack <= 1'b0;
		if (reg_req === 1'b1 && !reg_ack) begin
			if (wait_cnt >= reg_lat) begin
				reg_ack <= 1'b1;
				wait_cnt <= 0;
				n_req <= n_req + 1;
				last <= {reg_wr, reg_cfg, reg_idx, reg_wd};
			end else begin
				wait_cnt <= wait_cnt + 1;
			end
		end
		if (soft_rst === 1'b1) begin
			n_soft <= n_soft + 1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Tasks
	task automatic check(input string what, input logic [33:0] seen,
		input logic [33:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		if (err_total == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic hang();
		err_total++;
		tally_and_finish();
	endtask

	// One APB transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) hang();
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	// One host ISA operation: load, go, poll status, fetch read data
	task automatic isa(input logic wr, input logic word,
		input logic [4:0] off, input logic [15:0] wd);
		logic [31:0] c;
		int k;
		c = 32'h0;
		c[isio_pkg::CTRL_OFF_LSB +: 5] = off;
		c[isio_pkg::CTRL_WR_BIT] = wr;
		c[isio_pkg::CTRL_WORD_BIT] = word;
		c[isio_pkg::CTRL_GO_BIT] = 1'b1;
		apb(1'b1, isio_pkg::HREG_WDATA, {16'h0, wd});
		apb(1'b1, isio_pkg::HREG_CTRL, c);
		k = 0;
		do begin
			apb(1'b0, isio_pkg::HREG_STATUS, 32'h0);
			k++;
		end while ((q[isio_pkg::STAT_DONE] !== 1'b1
			|| q[isio_pkg::STAT_BUSY] !== 1'b0) && k < 100);
		if (k >= 100) hang();
		st = q[3:0];
		apb(1'b0, isio_pkg::HREG_RDATA, 32'h0);
		rd = q[15:0];
	endtask

	////////////////////////////////////////////////////////////////////
	// Hang guard
	initial begin
		repeat (100000) @(posedge clock);
		hang();
	end

	// Main sequence
	initial begin
		clock = 1'b0; rst_n = 1'b0; io16 = 1'b1; sys8 = 1'b0;
		slave = 1'b1; pio = 1'b0; mreq = 1'b0; boot_cfg = 8'h3c;
		boot_strap = 8'hc3; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h0; pwdata = 32'h0; reg_rd = 16'h0;
		reg_lat = 0;
		err_total = 0; n_checks = 0;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		apb(1'b1, isio_pkg::HREG_BASE, {27'h0, BASE});
		apb(1'b0, 8'h20, 32'h0);
		check("apb_unmapped", {1'b0, perr, q}, {2'b01, 32'h0});
		// Station words as 16-bit resources
		for (int i = 0; i < 16; i += 2) begin
			isa(1'b0, 1'b1, 5'(i), 16'h0);
			check("station", {18'h0, rd}, {18'h0, STATION[8*i +: 16]});
		end
		check("wide_status", {30'h0, st}, {30'h0, 4'b0110});
		isa(1'b0, 1'b0, 5'h05, 16'h0);
		check("odd_byte", {26'h0, rd[15:8]}, {26'h0, 8'ha5});
		// 8-bit mode: split word, index then data port, slow config read
		io16 <= 1'b0;
		isa(1'b0, 1'b1, 5'h06, 16'h0);
		check("split_rd", {18'h0, rd}, {18'h0, 16'ha7a6});
		check("split_st", {30'h0, st}, {30'h0, 4'b1010});
		n0 = n_req;
		isa(1'b1, 1'b1, 5'h12, 16'h0005);
		isa(1'b1, 1'b1, 5'h10, 16'h1234);
		check("data_wr", last, {2'b10, 16'h0005, 16'h1234});
		reg_lat = 6;
		reg_rd <= 16'hbeef;
		isa(1'b0, 1'b1, 5'h16, 16'h0);
		check("cfg_rd", {18'h0, rd}, {18'h0, 16'hbeef});
		check("cfg_sel", {32'h0, last[33:32]}, {32'h0, 2'b01});
		check("one_access", 34'(n_req - n0), 34'd2);
		isa(1'b1, 1'b0, 5'h10, 16'h0033);
		check("hold_only", 34'(n_req - n0), 34'd2);
		isa(1'b1, 1'b0, 5'h11, 16'h4400);
		check("merge", last, {2'b10, 16'h0005, 16'h4433});
		// Reset port: writes ignored, byte read resets and clears index
		s0 = n_soft;
		isa(1'b1, 1'b1, 5'h14, 16'hffff);
		isa(1'b0, 1'b1, 5'h12, 16'h0);
		check("rst_wr", {2'b0, 16'(n_soft - s0), rd},
			{18'h0, 16'h0005});
		io16 <= 1'b1;
		isa(1'b0, 1'b0, 5'h14, 16'h0);
		check("rst_rd", {14'h0, 16'(n_soft - s0), st},
			{14'h0, 16'h1, 4'b0010});
		isa(1'b0, 1'b1, 5'h12, 16'h0);
		check("idx_soft", {18'h0, rd}, {18'h0, 16'h0});
		// Unclaimed: offset 18h, then a base mismatch
		n0 = n_req;
		isa(1'b0, 1'b1, 5'h18, 16'h0);
		check("off_18", {18'h0, rd}, {18'h0, 16'hffff});
		apb(1'b1, isio_pkg::HREG_BASE, 32'h0b);
		isa(1'b1, 1'b1, 5'h10, 16'h5555);
		isa(1'b0, 1'b1, 5'h12, 16'h0);
		check("base_miss", {2'(n_req - n0), 16'h0, rd},
			{18'h0, 16'hffff});
		apb(1'b1, isio_pkg::HREG_BASE, {27'h0, BASE});
		// 8-bit system forces byte cycles
		sys8 <= 1'b1;
		isa(1'b0, 1'b1, 5'h00, 16'h0);
		check("sys8", {14'h0, rd, st}, {14'h0, 16'ha1a0, 4'b1010});
		// Every strap combination on the mode outputs
		for (int i = 0; i < 16; i++) begin
			{sys8, mreq, pio, slave} <= 4'(i);
			repeat (3) @(posedge clock);
			check("modes", {23'h0, sram_sh, sram_pio, master_en, boot_base},
				{23'h0, slave & ~pio, slave & pio, mreq & ~slave & ~sys8,
				slave ? boot_strap : boot_cfg});
		end
		{sys8, mreq, pio, slave} <= 4'b0001;
		// Hardware reset mid-run clears the index
		isa(1'b1, 1'b1, 5'h12, 16'h0007);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		apb(1'b1, isio_pkg::HREG_BASE, {27'h0, BASE});
		isa(1'b0, 1'b1, 5'h12, 16'h0);
		check("idx_hard", {18'h0, rd}, {18'h0, 16'h0});
		tally_and_finish();
	end
endmodule
